// File: src/fault_restart_pkg.sv
// Shared constants for the fault and restart manager
package fault_restart_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS        = 8'h00;
    localparam logic [7:0] STATUS_OFS      = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFS  = 8'h08;
    localparam logic [7:0] IRQ_CLEAR_OFS   = 8'h0c;
    localparam logic [7:0] IRQ_ENABLE_OFS  = 8'h10;
    localparam logic [7:0] BATT_VOLT_OFS   = 8'h14;
    localparam logic [7:0] BASE_SPEED_OFS  = 8'h18;
    localparam logic [7:0] SPEED_LIM_OFS   = 8'h1c;

    // Control register fields and reset value
    localparam int CTRL_LIMIT_LSB   = 0;
    localparam int CTRL_LIMIT_W     = 4;
    localparam int CTRL_RELAY_BIT   = 4;
    localparam int CTRL_GND_EN_BIT  = 5;
    localparam int CTRL_CLASS_BIT   = 6;
    localparam logic [31:0] CTRL_RESET = 32'h00000012;

    // Status register fields
    localparam int STAT_CODE_LSB    = 0;
    localparam int STAT_RETRY_BIT   = 8;
    localparam int STAT_LATCH_BIT   = 9;
    localparam int STAT_POWER_BIT   = 10;
    localparam int STAT_COUNT_LSB   = 12;

    // Interrupt event bits
    localparam int IRQ_W            = 3;
    localparam int IRQ_FAULT_BIT    = 0;
    localparam int IRQ_RESTART_BIT  = 1;
    localparam int IRQ_LATCH_BIT    = 2;

    // Fault vector layout; code shown is index plus one, zero means no fault
    localparam int NFAULT           = 13;
    localparam int F_BUS_UV         = 0;
    localparam int F_GND_LEAK       = 1;
    localparam int F_OVERCURRENT    = 2;
    localparam int F_BUS_OV         = 3;
    localparam int F_OVERLOAD       = 4;
    localparam int F_OVERTORQUE1    = 5;
    localparam int F_OVERTORQUE2    = 6;
    localparam int F_UNDERTORQUE1   = 7;
    localparam int F_UNDERTORQUE2   = 8;
    localparam int F_IN_PHASE       = 9;
    localparam int F_OUT_PHASE      = 10;
    localparam int F_FUSE_OPEN      = 11;
    localparam int F_OTHER          = 12;
    localparam logic [NFAULT-1:0] AUTO_RESET_MASK = 13'h07ff;
    localparam int CODE_W           = 5;

    // Timing
    localparam longint CLK_HZ            = 100000000;
    localparam longint RETRY_INTERVAL_MS = 2000;
    localparam int RETRY_CYCLES = int'(RETRY_INTERVAL_MS * CLK_HZ / 1000);

    // Battery speed limit divisors in volts (twice the class reference)
    localparam logic [10:0] BATT_DIV_LOW  = 11'd600;
    localparam logic [10:0] BATT_DIV_HIGH = 11'd1200;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_RETRY_WAIT,
        ST_LATCHED
    } mgr_state_t;

endpackage

// File: src/fault_encoder.sv
// Priority encoder from fault flags to a displayed fault code
module fault_encoder
    import fault_restart_pkg::*;
#(
    parameter int N = NFAULT
) (
    // Fault flags and class mask
    input  wire logic [N-1:0]      faults,
    input  wire logic [N-1:0]      auto_mask,
    // Encoded result
    output logic [CODE_W-1:0] code,
    output logic              any,
    output logic              auto_ok
);

    // Highest index wins so that the power-cycle faults take precedence
    always_comb begin
        code    = '0;
        auto_ok = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (faults[i]) begin
                code    = CODE_W'(i + 1);
                auto_ok = auto_mask[i];
            end
        end
        any = |faults;
    end

endmodule // fault_encoder

// File: src/fault_restart_manager.sv
// Fault handling, automatic restart and battery speed limit with AXI4-Lite registers
module fault_restart_manager
    import fault_restart_pkg::*;
#(
    parameter int RETRY_WAIT_CYCLES = RETRY_CYCLES
) (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        ce,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Discrete fault detectors
    input  wire logic        bus_undervoltage_fault,
    input  wire logic        bus_overvoltage_fault,
    input  wire logic        drive_overload_fault,
    input  wire logic        overtorque_fault_one,
    input  wire logic        overtorque_fault_two,
    input  wire logic        undertorque_fault_one,
    input  wire logic        undertorque_fault_two,
    input  wire logic        input_phase_loss_fault,
    input  wire logic        output_phase_loss_fault,
    input  wire logic        bus_fuse_open_fault,
    input  wire logic        other_hard_fault,
    // Current measurements
    input  wire logic [15:0] ground_current,
    input  wire logic [15:0] rated_current,
    input  wire logic [15:0] output_current,
    input  wire logic [15:0] overcurrent_level,
    // Controller commands
    input  wire logic        run_cmd,
    input  wire logic        reset_in,
    input  wire logic        reset_key,
    input  wire logic        base_block,
    input  wire logic        battery_mode,
    // Drive outputs
    output logic             fault_relay_terminals,
    output logic             power_enable,
    output logic [CODE_W-1:0] fault_code,
    output logic             restart_pulse,
    output logic [15:0]      speed_limit,
    output logic             irq
);

    mgr_state_t         state_ff, nxt_state;
    logic [31:0]        ctrl_ff;
    logic [9:0]         batt_volt_ff;
    logic [15:0]        base_speed_ff;
    logic [IRQ_W-1:0]   irq_stat_ff, irq_en_ff;
    logic [3:0]         count_ff;
    logic [31:0]        timer_ff;
    logic [CODE_W-1:0]  code_ff;
    logic               power_ff, relay_ff, restart_ff;
    logic [15:0]        speed_ff;
    logic               aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
    logic [7:0]         awaddr_ff;
    logic [31:0]        wdata_ff, rdata_ff;
    logic [3:0]         wstrb_ff;
    logic [1:0]         bresp_ff, rresp_ff;

    // Fault detection
    wire logic          gnd_en   = ctrl_ff[CTRL_GND_EN_BIT];
    wire logic          gnd_leak = gnd_en && ({ground_current, 1'b0} > {1'b0, rated_current});
    wire logic          over_cur = output_current > overcurrent_level;
    wire logic [NFAULT-1:0] faults = {other_hard_fault, bus_fuse_open_fault,
                                      output_phase_loss_fault, input_phase_loss_fault,
                                      undertorque_fault_two, undertorque_fault_one,
                                      overtorque_fault_two, overtorque_fault_one,
                                      drive_overload_fault, bus_overvoltage_fault,
                                      over_cur, gnd_leak, bus_undervoltage_fault};
    logic [CODE_W-1:0]  enc_code;
    logic               any_fault, auto_ok;

    fault_encoder #(.N(NFAULT)) u_enc (
        .faults    (faults),
        .auto_mask (AUTO_RESET_MASK),
        .code      (enc_code),
        .any       (any_fault),
        .auto_ok   (auto_ok)
    );

    // Sequencing conditions
    wire logic [3:0] limit       = ctrl_ff[CTRL_LIMIT_LSB +: CTRL_LIMIT_W];
    wire logic       relay_sel   = ctrl_ff[CTRL_RELAY_BIT];
    wire logic       retry_ok    = auto_ok && (count_ff < limit);
    wire logic       timer_done  = timer_ff >= 32'(RETRY_WAIT_CYCLES - 1);
    wire logic       auto_go     = timer_done && !any_fault && base_block;
    wire logic       cur_auto    = |(AUTO_RESET_MASK & (NFAULT'(1) << (code_ff - CODE_W'(1))));
    wire logic       manual_go   = (reset_in || reset_key) && !any_fault && !run_cmd
                                   && cur_auto;
    wire logic       go_normal   = (state_ff == ST_RETRY_WAIT && (auto_go || manual_go))
                                   || (state_ff == ST_LATCHED && manual_go);
    wire logic       new_fault   = (state_ff == ST_NORMAL) && any_fault;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_NORMAL: begin
                if (any_fault) begin
                    nxt_state = retry_ok ? ST_RETRY_WAIT : ST_LATCHED;
                end
            end
            ST_RETRY_WAIT, ST_LATCHED: begin
                if (go_normal) begin
                    nxt_state = ST_NORMAL;
                end
            end
        endcase
    end

    wire logic       enter_latch = new_fault && !retry_ok;
    wire logic       auto_restart = state_ff == ST_RETRY_WAIT && auto_go && !manual_go;
    wire logic [3:0] nxt_count = manual_go && go_normal ? 4'h0 :
                                 auto_restart ? count_ff + 4'h1 : count_ff;
    wire logic [31:0] nxt_timer = (state_ff != ST_RETRY_WAIT) ? 32'h0 :
                                  timer_done ? timer_ff : timer_ff + 32'h1;
    wire logic [CODE_W-1:0] nxt_code = new_fault ? enc_code :
                                       (go_normal ? {CODE_W{1'b0}} : code_ff);
    wire logic       nxt_power = (nxt_state == ST_NORMAL) && !any_fault;
    wire logic       nxt_relay = (nxt_state == ST_LATCHED)
                                 || (nxt_state == ST_RETRY_WAIT && relay_sel);

    // Battery speed limit
    wire logic [10:0] batt_div  = ctrl_ff[CTRL_CLASS_BIT] ? BATT_DIV_HIGH : BATT_DIV_LOW;
    wire logic [25:0] batt_prod = batt_volt_ff * base_speed_ff;
    wire logic [25:0] batt_quot = batt_prod / {15'h0, batt_div};
    wire logic [15:0] nxt_speed = !battery_mode ? base_speed_ff :
                                  (batt_quot > {10'h0, base_speed_ff}) ? base_speed_ff :
                                  batt_quot[15:0];

    // Interrupt events
    wire logic [IRQ_W-1:0] irq_evt = {enter_latch, auto_restart, new_fault};

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff   <= ST_NORMAL;
            count_ff   <= 4'h0;
            timer_ff   <= 32'h0;
            code_ff    <= '0;
            power_ff   <= 1'b0;
            relay_ff   <= 1'b0;
            restart_ff <= 1'b0;
            speed_ff   <= 16'h0;
        end else if (ce) begin
            state_ff   <= nxt_state;
            count_ff   <= nxt_count;
            timer_ff   <= nxt_timer;
            code_ff    <= nxt_code;
            power_ff   <= nxt_power;
            relay_ff   <= nxt_relay;
            restart_ff <= auto_restart;
            speed_ff   <= nxt_speed;
        end
    end

    // AXI4-Lite write path
    wire logic       do_write  = aw_held_ff && w_held_ff && !bvalid_ff;
    wire logic [31:0] wmask    = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                                  {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    wire logic       wr_ctrl   = do_write && awaddr_ff == CTRL_OFS;
    wire logic       wr_clr    = do_write && awaddr_ff == IRQ_CLEAR_OFS;
    wire logic       wr_en     = do_write && awaddr_ff == IRQ_ENABLE_OFS;
    wire logic       wr_batt   = do_write && awaddr_ff == BATT_VOLT_OFS;
    wire logic       wr_speed  = do_write && awaddr_ff == BASE_SPEED_OFS;
    wire logic       wr_ok     = wr_ctrl || wr_clr || wr_en || wr_batt || wr_speed;
    wire logic [31:0] wmerge_ctrl = (ctrl_ff & ~wmask) | (wdata_ff & wmask);
    wire logic [31:0] wmerge_batt = ({22'h0, batt_volt_ff} & ~wmask) | (wdata_ff & wmask);
    wire logic [31:0] wmerge_spd  = ({16'h0, base_speed_ff} & ~wmask) | (wdata_ff & wmask);
    wire logic [IRQ_W-1:0] clr_bits = wr_clr && wstrb_ff[0] ? wdata_ff[IRQ_W-1:0] : '0;
    // Set wins over a clear in the same cycle
    wire logic [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~clr_bits) | irq_evt;

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= 2'b00;
            awaddr_ff  <= 8'h0;
            wdata_ff   <= 32'h0;
            wstrb_ff   <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_ok ? 2'b00 : 2'b10;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff       <= CTRL_RESET;
            batt_volt_ff  <= 10'h0;
            base_speed_ff <= 16'h0;
            irq_stat_ff   <= '0;
            irq_en_ff     <= '0;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_ff <= {25'h0, wmerge_ctrl[6:0]};
            end
            if (wr_batt) begin
                batt_volt_ff <= wmerge_batt[9:0];
            end
            if (wr_speed) begin
                base_speed_ff <= wmerge_spd[15:0];
            end
            if (wr_en && wstrb_ff[0]) begin
                irq_en_ff <= wdata_ff[IRQ_W-1:0];
            end
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    // AXI4-Lite read path
    wire logic [7:0]  raddr = {s_axi_araddr[7:2], 2'b00};
    wire logic [31:0] status_word = {16'h0, count_ff, 1'b0, power_ff,
                                     state_ff == ST_LATCHED, state_ff == ST_RETRY_WAIT,
                                     3'h0, code_ff};
    wire logic        rd_hit = raddr <= SPEED_LIM_OFS; // Map is contiguous
    wire logic [31:0] rd_mux =
        raddr == CTRL_OFS       ? ctrl_ff :
        raddr == STATUS_OFS     ? status_word :
        raddr == IRQ_STATUS_OFS ? {29'h0, irq_stat_ff} :
        raddr == IRQ_ENABLE_OFS ? {29'h0, irq_en_ff} :
        raddr == BATT_VOLT_OFS  ? {22'h0, batt_volt_ff} :
        raddr == BASE_SPEED_OFS ? {16'h0, base_speed_ff} :
        raddr == SPEED_LIM_OFS  ? {16'h0, speed_ff} : 32'h0;

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0;
            rresp_ff  <= 2'b00;
        end else if (ce) begin
            if (s_axi_arvalid && !rvalid_ff) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rd_mux;
                rresp_ff  <= rd_hit ? 2'b00 : 2'b10;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Drive outputs
    assign fault_relay_terminals = relay_ff;
    assign power_enable          = power_ff;
    assign fault_code            = code_ff;
    assign restart_pulse         = restart_ff;
    assign speed_limit           = speed_ff;
    assign irq                   = |(irq_stat_ff & irq_en_ff);

endmodule // fault_restart_manager

// File: sim/fault_restart_manager_assertions.sv
// Checker of fault, restart and reset timing at the manager's ports
module fault_restart_checker
    import fault_restart_pkg::*;
#(
    parameter int RETRY_WAIT_CYCLES = RETRY_CYCLES
) (
    // Clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              ce,
    // Fault and command inputs
    input  wire logic              bus_overvoltage_fault,
    input  wire logic              bus_fuse_open_fault,
    input  wire logic              other_hard_fault,
    input  wire logic              run_cmd,
    input  wire logic              reset_in,
    input  wire logic              reset_key,
    input  wire logic              base_block,
    // Drive outputs
    input  wire logic              fault_relay_terminals,
    input  wire logic              power_enable,
    input  wire logic [CODE_W-1:0] fault_code,
    input  wire logic              restart_pulse
);
    logic [31:0] low_cnt_ff;
    logic [31:0] nxt_low_cnt;
    logic        fault_seen;
    // Edges spent with power off, to judge restart spacing
    assign nxt_low_cnt = power_enable ? 32'h0 : low_cnt_ff + 32'h1;
    assign fault_seen  = bus_overvoltage_fault || bus_fuse_open_fault || other_hard_fault;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            low_cnt_ff <= 32'h0;
        end else if (ce) begin
            low_cnt_ff <= nxt_low_cnt;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence s_back_to_run;
        power_enable && fault_code == 5'h00 ##1 !restart_pulse;
    endsequence
    property p_fault_off;
        ce && fault_seen |=> !power_enable;
    endproperty
    property p_fault_code;
        ce && fault_seen |=> fault_code != 5'h00;
    endproperty
    property p_relay_fault;
        fault_relay_terminals |-> !power_enable && fault_code != 5'h00;
    endproperty
    property p_hard_latch;
        fault_code == 5'h0c || fault_code == 5'h0d |=>
            !restart_pulse && !power_enable && $stable(fault_code);
    endproperty
    property p_restart_bb;
        restart_pulse |-> $past(base_block);
    endproperty
    property p_restart_wait;
        restart_pulse |-> low_cnt_ff >= RETRY_WAIT_CYCLES;
    endproperty
    property p_restart_run;
        restart_pulse |-> s_back_to_run;
    endproperty
    property p_manual;
        $rose(power_enable) && !restart_pulse && $past(fault_code) != 5'h00 |->
            !$past(run_cmd) && ($past(reset_in) || $past(reset_key));
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("power on after fault");
    a_fault_code: assert property (p_fault_code) else $error("no fault code");
    a_relay_fault: assert property (p_relay_fault) else $error("relay without fault");
    a_hard_latch: assert property (p_hard_latch) else $error("hard fault left latch");
    a_restart_bb: assert property (p_restart_bb) else $error("restart without base block");
    a_restart_wait: assert property (p_restart_wait) else $error("restart too early");
    a_restart_run: assert property (p_restart_run) else $error("restart not clean");
    a_manual: assert property (p_manual) else $error("reset taken while refused");
endmodule // fault_restart_checker

bind fault_restart_manager fault_restart_checker #(
    .RETRY_WAIT_CYCLES(RETRY_WAIT_CYCLES)
) u_checker (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .bus_overvoltage_fault(bus_overvoltage_fault), .bus_fuse_open_fault(bus_fuse_open_fault),
    .other_hard_fault(other_hard_fault), .run_cmd(run_cmd), .reset_in(reset_in),
    .reset_key(reset_key), .base_block(base_block),
    .fault_relay_terminals(fault_relay_terminals), .power_enable(power_enable),
    .fault_code(fault_code), .restart_pulse(restart_pulse)
);

// File: sim/lift_ctrl_model.sv
// Lift controller model driving run, reset and base block
module lift_ctrl_model (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Requests from the bench
    input  wire logic want_run,
    input  wire logic want_reset,
    input  wire logic want_bb,
    // Commands to the drive
    output logic      run_cmd,
    output logic      reset_in,
    output logic      base_block
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_cmd    <= 1'h0;
            reset_in   <= 1'h0;
            base_block <= 1'h0;
        end else begin
            run_cmd    <= want_run && !want_reset;
            reset_in   <= want_reset && !run_cmd;
            base_block <= want_bb || want_reset;
        end
    end
endmodule // lift_ctrl_model

// File: sim/tb.sv
// Self-checking bench of the fault and restart manager
module tb
    import fault_restart_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 20;
    logic        clk_sys = 1'h0, rstn = 1'h0, ce = 1'h1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, relay, pwr, pulse, irq;
    logic [1:0]  bresp, rresp, rr;
    logic [12:0] hw = 13'h0;
    logic [15:0] gnd_i = 16'h0, rated = 16'h0064, out_i = 16'h0, oc_lvl = 16'h0064, spd;
    logic        want_run = 1'h1, want_reset = 1'h0, want_bb = 1'h1, reset_key = 1'h0;
    logic        batt = 1'h0, run_cmd, reset_in, base_block;
    logic [4:0]  code;
    int          fail_count = 0, n_compared = 0, cyc = 0, pulses = 0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (pulse === 1'h1) pulses <= pulses + 1;
    lift_ctrl_model u_ctrl (.clk_sys(clk_sys), .rstn(rstn), .want_run(want_run),
        .want_reset(want_reset), .want_bb(want_bb), .run_cmd(run_cmd),
        .reset_in(reset_in), .base_block(base_block));
    fault_restart_manager #(.RETRY_WAIT_CYCLES(W)) dut (.clk_sys(clk_sys), .rstn(rstn),
        .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_undervoltage_fault(hw[0]),
        .bus_overvoltage_fault(hw[3]), .drive_overload_fault(hw[4]),
        .overtorque_fault_one(hw[5]), .overtorque_fault_two(hw[6]),
        .undertorque_fault_one(hw[7]), .undertorque_fault_two(hw[8]),
        .input_phase_loss_fault(hw[9]), .output_phase_loss_fault(hw[10]),
        .bus_fuse_open_fault(hw[11]), .other_hard_fault(hw[12]), .ground_current(gnd_i),
        .rated_current(rated), .output_current(out_i), .overcurrent_level(oc_lvl),
        .run_cmd(run_cmd), .reset_in(reset_in), .reset_key(reset_key),
        .base_block(base_block), .battery_mode(batt), .fault_relay_terminals(relay),
        .power_enable(pwr), .fault_code(code), .restart_pulse(pulse), .speed_limit(spd),
        .irq(irq));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_d = 1'h0, w_d = 1'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_d && w_d)) begin
            @(posedge clk_sys);
            if (awready && !aw_d) begin
                aw_d = 1'h1;
                awvalid <= 1'h0;
            end
            if (wready && !w_d) begin
                w_d = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge clk_sys); while (!bvalid);
        rr = bresp;
        bready <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk_sys); while (!rvalid);
        rv = rdata;
        rr = rresp;
        rready <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic wait_up(input int n);
        cyc = 0;
        while (pwr !== 1'h1 && cyc < n) begin
            @(posedge clk_sys);
            cyc++;
        end
        @(posedge clk_sys);
    endtask
    task automatic hit(input int i, input logic [4:0] e);
        hw[i] <= 1'h1;
        repeat (2) @(posedge clk_sys);
        chk("fault_code", e, code);
        chk("power_enable", 0, pwr);
        hw[i] <= 1'h0;
    endtask
    task automatic t_regs;
        rd(CTRL_OFS);
        chk("ctrl_reset", 32'h12, rv);
        rd(IRQ_ENABLE_OFS);
        chk("irq_en_reset", 0, rv);
        rd(8'h20);
        chk("bad_rresp", 2'b10, rr);
        wr(8'h20, 32'h1);
        chk("bad_bresp", 2'b10, rr);
    endtask
    task automatic t_classes;
        int al[9] = '{0, 3, 4, 5, 6, 7, 8, 9, 10};
        wr(CTRL_OFS, 32'h1f);
        foreach (al[k]) begin
            hit(al[k], 5'(al[k] + 1));
            wait_up(W + 10);
            chk("restart_count", k + 1, pulses);
            chk("retry_gap", 1, cyc >= W - 1);
        end
        rd(STATUS_OFS);
        chk("retry_total", 9, rv[15:12]);
        hit(12, 13);
        wait_up(W + 10);
        chk("hard_stays_off", 0, pwr);
        rstn <= 1'h0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'h1;
        wait_up(5);
        chk("power_cycle", 1, pwr);
    endtask
    task automatic t_limit;
        want_bb <= 1'h0;
        hit(3, 4);
        repeat (W + 10) @(posedge clk_sys);
        chk("no_base_block", 0, pwr);
        chk("relay_retry", 1, relay);
        want_bb <= 1'h1;
        wait_up(20);
        hit(3, 4);
        wait_up(W + 10);
        hit(3, 4);
        wait_up(W + 10);
        chk("limit_latched", 0, pwr);
        rd(STATUS_OFS);
        chk("latch_status", 32'h5, {rv[15:12], rv[9]});
        reset_key <= 1'h1;
        repeat (10) @(posedge clk_sys);
        chk("reset_while_run", 0, pwr);
        want_run <= 1'h0;
        wait_up(10);
        chk("reset_key_taken", 1, pwr);
        reset_key <= 1'h0;
        want_run <= 1'h1;
        rd(STATUS_OFS);
        chk("count_cleared", 0, rv[15:12]);
        wr(CTRL_OFS, 32'h02);
        want_bb <= 1'h0;
        hit(0, 1);
        chk("relay_quiet", 0, relay);
        want_reset <= 1'h1;
        wait_up(10);
        want_reset <= 1'h0;
        want_bb <= 1'h1;
        chk("reset_input", 1, pwr);
    endtask
    task automatic t_gnd_oc;
        wr(IRQ_CLEAR_OFS, 32'h7);
        wr(IRQ_ENABLE_OFS, 32'h7);
        wr(CTRL_OFS, 32'h0f);
        gnd_i <= 16'd60;
        repeat (5) @(posedge clk_sys);
        chk("gnd_disabled", 1, pwr);
        wr(CTRL_OFS, 32'h2f);
        chk("gnd_code", 2, code);
        gnd_i <= 16'd50;
        wait_up(W + 10);
        chk("gnd_half_ok", 1, pwr);
        out_i <= 16'd100;
        repeat (5) @(posedge clk_sys);
        chk("oc_equal", 1, pwr);
        out_i <= 16'd101;
        repeat (3) @(posedge clk_sys);
        chk("oc_code", 3, code);
        out_i <= 16'd0;
        wait_up(W + 10);
        chk("irq_set", 1, irq);
        rd(IRQ_STATUS_OFS);
        chk("irq_status", 32'h3, rv);
        wr(IRQ_ENABLE_OFS, 32'h0);
        chk("irq_masked", 0, irq);
        wr(IRQ_ENABLE_OFS, 32'h7);
        wr(IRQ_CLEAR_OFS, 32'h7);
        chk("irq_cleared", 0, irq);
    endtask
    task automatic t_batt;
        wr(BATT_VOLT_OFS, 32'd300);
        wr(BASE_SPEED_OFS, 32'd1000);
        chk("speed_mains", 16'd1000, spd);
        batt <= 1'h1;
        repeat (3) @(posedge clk_sys);
        chk("speed_low_class", 16'd500, spd);
        wr(CTRL_OFS, 32'h52);
        rd(SPEED_LIM_OFS);
        chk("speed_high_class", 32'd250, rv);
        batt <= 1'h0;
    endtask
    task automatic finish_test;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'h1;
        @(posedge clk_sys);
        t_regs;
        t_classes;
        t_limit;
        t_gnd_oc;
        t_batt;
        finish_test;
    end
    initial begin
        repeat (6000) @(posedge clk_sys);
        fail_count++;
        finish_test;
    end
endmodule // tb
